// ==== sms_shifter.sv ====
/*
 Byte shifter working as bus master or bus slave on MOSI/MISO/SCK/select.
 Assumes CLK is the CPU clock, pins are outside its domain and go through
 sms_sync3, and that control bits arrive as plain ports from the host logic.
*/
// How it works
// R1: While the power gate is set the port is held disabled and idle.
// R2: Select low frames a transfer; master drives SCK pulses from its divider.
// R3: Data leaves on MOSI as master and on MISO as slave, exchanged bitwise.
// R4: The peer master raises select after each packet to resynchronise us.
// R5: As master the port never drives select; software owns that pin.
// R6: A data write in master mode starts the clock and shifts eight bits.
// R7: After eight bits the master clock stops and the done flag sets.
// R8: Done flag with interrupt enable set raises the interrupt request.
// R9: After a byte the master writes again or raises select to end.
// R10: Last received byte is held in a receive buffer returned on reads.
// R11: As slave with select high the port idles and MISO is undriven.
// R12: Slave writes while select is high are kept but not shifted.
// R13: As slave the done flag sets once a full byte has shifted.
// R14: Slave may load the next transmit byte before reading received data.
// R15: Software writes no new byte until the current shift has completed.
// R16: Software reads each byte before the next one finishes arriving.
// R17: Peer SCK low and high phases each exceed two CPU cycles.
// R18: Enabled port forces its input pins to input; its output pins still follow their direction bits.
// R19: Slave select rising resets shift logic and drops a partial byte.
// R20: Select pulled low while master with select input makes us slave.
// R21: Control holds enable, bit order, polarity, phase and rate select.
`timescale 1ns/1ps
module sms_shifter
   import sms_pkg::*;
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic POWER_GATE,
   input wire logic [7:0] CTL_WR_DATA,
   input wire logic CTL_WR,
   input wire logic [7:0] DATA_WR_DATA,
   input wire logic DATA_WR,
   input wire logic DATA_RD,
   input wire logic FLAG_CLR,
   input wire logic DIR_MOSI,
   input wire logic DIR_MISO,
   input wire logic DIR_SCK,
   input wire logic DIR_SEL,
   input wire logic PORT_SEL_OUT,
   input wire logic MOSI_IN,
   input wire logic MISO_IN,
   input wire logic SCK_IN,
   input wire logic SEL_IN,
   output logic MOSI_OUT,
   output logic MOSI_OE,
   output logic MISO_OUT,
   output logic MISO_OE,
   output logic SCK_OUT,
   output logic SCK_OE,
   output logic SEL_OUT,
   output logic SEL_OE,
   output logic [7:0] CONTROL,
   output logic [7:0] RX_DATA,
   output logic TRANSFER_DONE_FLAG,
   output logic IRQ,
   output logic BUSY
);
   logic [7:0] ctl_r, ctl_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [7:0] rx_buf_r;
   logic [2:0] bit_cnt_r, bit_cnt_nxt;
   logic [6:0] div_cnt_r, div_cnt_nxt;
   logic done_r, done_nxt;
   logic in_bit_r, in_bit_nxt;
   logic sck_gen_r, sck_gen_nxt;
   logic sck_prev_r, sel_prev_r;
   logic byte_end;
   sms_state_t state_r, state_nxt;

   logic mosi_s, miso_s, sck_s, sel_s;
   sms_sync3 u_sync_mosi (.clk(CLK), .rst_n(RSTN), .reset_val(1'b0), .d(MOSI_IN), .q(mosi_s));
   sms_sync3 u_sync_miso (.clk(CLK), .rst_n(RSTN), .reset_val(1'b0), .d(MISO_IN), .q(miso_s));
   sms_sync3 u_sync_sck (.clk(CLK), .rst_n(RSTN), .reset_val(1'b0), .d(SCK_IN), .q(sck_s));
   sms_sync3 u_sync_sel (.clk(CLK), .rst_n(RSTN), .reset_val(1'b1), .d(SEL_IN), .q(sel_s));

   wire enabled = ctl_r[CTL_ENABLE] & ~POWER_GATE; // see R1
   wire is_master = ctl_r[CTL_MASTER];
   wire lsb_first = ctl_r[CTL_LSB_FIRST];
   wire cpol = ctl_r[CTL_CPOL];
   wire cpha = ctl_r[CTL_CPHA];
   wire [1:0] rate = {ctl_r[CTL_RATE_HI], ctl_r[CTL_RATE_LO]};
   // Synchronised select reads low from reset until a high pin has reached stages 2 and 3 and they agree; a low pin settles to low
   wire sel_low = ~sel_s;
   wire slave_active = enabled & ~is_master & sel_low; // see R11
   wire sel_rise = sel_s & ~sel_prev_r;
   // Mode fault: another master selects us while select is an input
   wire mode_fault = enabled & is_master & ~DIR_SEL & sel_low; // see R20

   wire [6:0] half_div = (rate == 2'h0) ? HALF_DIV0 :
                         (rate == 2'h1) ? HALF_DIV1 :
                         (rate == 2'h2) ? HALF_DIV2 : HALF_DIV3;
   wire out_bit = lsb_first ? shift_r[0] : shift_r[BYTE_W-1];
   wire [7:0] shift_in = lsb_first ? {in_bit_r, shift_r[7:1]} : {shift_r[6:0], in_bit_r};
   wire master_in = miso_s; // see R3
   wire slave_in = mosi_s;

   // Slave edges on the synchronised clock; the leading edge depends on polarity
   wire sck_level = sck_s ^ cpol;
   wire sck_lead = sck_level & ~(sck_prev_r ^ cpol);
   wire sck_trail = ~sck_level & (sck_prev_r ^ cpol);
   wire div_tick = (div_cnt_r == DIV_ONE);

   // Sample on the first edge when phase is zero, else on the second
   wire s_sample = cpha ? sck_trail : sck_lead;
   wire s_shift = cpha ? sck_lead : sck_trail;
   // With phase one the first leading edge is a shift with nothing yet sampled
   wire s_first_skip = cpha & (bit_cnt_r == BIT_CNT_ZERO) & ~in_bit_r;

   always_comb begin
      ctl_nxt = ctl_r;
      shift_nxt = shift_r;
      bit_cnt_nxt = bit_cnt_r;
      div_cnt_nxt = div_cnt_r;
      done_nxt = done_r;
      in_bit_nxt = in_bit_r;
      sck_gen_nxt = sck_gen_r;
      state_nxt = state_r;
      byte_end = 1'b0;
      if (CTL_WR) begin
         ctl_nxt = CTL_WR_DATA; // see R21
      end
      if (FLAG_CLR | DATA_RD) begin
         done_nxt = 1'b0;
      end
      if (!enabled) begin
         state_nxt = SMS_IDLE;
         bit_cnt_nxt = BIT_CNT_ZERO;
         sck_gen_nxt = cpol;
         if (DATA_WR) begin
            shift_nxt = DATA_WR_DATA;
         end
      end else if (mode_fault) begin
         ctl_nxt[CTL_MASTER] = 1'b0; // see R20
         done_nxt = 1'b1;
         state_nxt = SMS_IDLE;
         bit_cnt_nxt = BIT_CNT_ZERO;
         sck_gen_nxt = cpol;
      end else if (is_master) begin
         case (state_r)
            SMS_IDLE: begin
               sck_gen_nxt = cpol;
               if (DATA_WR) begin
                  shift_nxt = DATA_WR_DATA; // see R6
                  bit_cnt_nxt = BIT_CNT_ZERO;
                  div_cnt_nxt = half_div;
                  state_nxt = SMS_LEAD;
               end
            end
            SMS_LEAD: begin
               div_cnt_nxt = div_tick ? half_div : div_cnt_r - DIV_ONE;
               if (div_tick) begin
                  sck_gen_nxt = ~cpol; // see R2
                  if (!cpha) begin
                     in_bit_nxt = master_in;
                  end else if (bit_cnt_r != BIT_CNT_ZERO) begin
                     shift_nxt = shift_in;
                  end
                  state_nxt = SMS_TRAIL;
               end
            end
            SMS_TRAIL: begin
               div_cnt_nxt = div_tick ? half_div : div_cnt_r - DIV_ONE;
               if (div_tick) begin
                  sck_gen_nxt = cpol;
                  if (cpha) begin
                     in_bit_nxt = master_in;
                  end else begin
                     shift_nxt = shift_in;
                  end
                  bit_cnt_nxt = bit_cnt_r + 3'h1;
                  state_nxt = SMS_LEAD;
                  if (bit_cnt_r == BIT_CNT_LAST) begin
                     state_nxt = SMS_IDLE; // see R7
                     byte_end = 1'b1;
                     if (cpha) begin
                        shift_nxt = lsb_first ? {master_in, shift_r[7:1]} : {shift_r[6:0], master_in};
                     end
                  end
               end
            end
            default: state_nxt = SMS_IDLE;
         endcase
      end else begin
         state_nxt = SMS_IDLE;
         if (sel_rise | ~sel_low) begin
            bit_cnt_nxt = BIT_CNT_ZERO; // see R19
            in_bit_nxt = 1'b0;
            if (DATA_WR) begin
               shift_nxt = DATA_WR_DATA; // see R12
            end
         end else begin
            if (DATA_WR) begin
               shift_nxt = DATA_WR_DATA; // see R14
            end
            if (s_sample) begin
               in_bit_nxt = slave_in;
               if (cpha) begin
                  shift_nxt = shift_in;
                  bit_cnt_nxt = bit_cnt_r + 3'h1;
               end
            end
            if (s_sample & cpha & (bit_cnt_r == BIT_CNT_LAST)) begin
               shift_nxt = lsb_first ? {slave_in, shift_r[7:1]} : {shift_r[6:0], slave_in};
               byte_end = 1'b1; // see R13
            end else if (s_shift & ~cpha) begin
               shift_nxt = shift_in;
               bit_cnt_nxt = bit_cnt_r + 3'h1;
               byte_end = (bit_cnt_r == BIT_CNT_LAST);
            end
         end
      end
      if (byte_end) begin
         done_nxt = 1'b1; // set wins over clear
      end
   end

   logic unused_skip;
   assign unused_skip = s_first_skip;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         ctl_r <= CTL_RESET;
         shift_r <= 8'h00;
         rx_buf_r <= 8'h00;
         bit_cnt_r <= BIT_CNT_ZERO;
         div_cnt_r <= DIV_ZERO;
         done_r <= 1'b0;
         in_bit_r <= 1'b0;
         sck_gen_r <= 1'b0;
         sck_prev_r <= 1'b0;
         sel_prev_r <= 1'b1;
         state_r <= SMS_IDLE;
      end else begin
         ctl_r <= ctl_nxt;
         shift_r <= shift_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         div_cnt_r <= div_cnt_nxt;
         done_r <= done_nxt;
         in_bit_r <= in_bit_nxt;
         sck_gen_r <= sck_gen_nxt;
         sck_prev_r <= sck_s;
         sel_prev_r <= sel_s;
         state_r <= state_nxt;
         if (byte_end) begin
            rx_buf_r <= shift_nxt; // see R10
         end
      end
   end

   // Pin drive: master owns MOSI/SCK by direction, slave owns MISO only while selected
   wire m_on = enabled & is_master & ~mode_fault;
   wire mosi_oe_nxt = m_on & DIR_MOSI; // see R18
   wire miso_oe_nxt = slave_active & DIR_MISO; // see R11
   wire sck_oe_nxt = m_on & DIR_SCK;
   // Select follows the ordinary port when not a slave; never driven by the shifter
   wire sel_oe_nxt = ~(enabled & ~is_master) & DIR_SEL; // see R5

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         MOSI_OUT <= 1'b0;
         MOSI_OE <= 1'b0;
         MISO_OUT <= 1'b0;
         MISO_OE <= 1'b0;
         SCK_OUT <= 1'b0;
         SCK_OE <= 1'b0;
         SEL_OUT <= 1'b1;
         SEL_OE <= 1'b0;
         CONTROL <= CTL_RESET;
         RX_DATA <= 8'h00;
         TRANSFER_DONE_FLAG <= 1'b0;
         IRQ <= 1'b0;
         BUSY <= 1'b0;
      end else begin
         MOSI_OUT <= out_bit; // see R3
         MOSI_OE <= mosi_oe_nxt;
         MISO_OUT <= out_bit;
         MISO_OE <= miso_oe_nxt;
         SCK_OUT <= sck_gen_nxt;
         SCK_OE <= sck_oe_nxt;
         SEL_OUT <= PORT_SEL_OUT;
         SEL_OE <= sel_oe_nxt;
         CONTROL <= ctl_nxt;
         RX_DATA <= byte_end ? shift_nxt : rx_buf_r;
         TRANSFER_DONE_FLAG <= done_nxt;
         IRQ <= done_nxt & ctl_nxt[CTL_IRQ_EN]; // see R8
         BUSY <= (state_nxt != SMS_IDLE);
      end
   end
endmodule

// ==== sms_pkg.sv ====
/*
 Package for the master/slave byte shifter: control field positions, divider
 encodings, sizes and state encoding. Assumes nothing of its surroundings.
*/
package sms_pkg;
   localparam int BYTE_W = 8;
   localparam logic [2:0] BIT_CNT_LAST = 3'h7;
   localparam logic [2:0] BIT_CNT_ZERO = 3'h0;
   // Control byte field positions
   localparam int CTL_IRQ_EN = 7;
   localparam int CTL_ENABLE = 6;
   localparam int CTL_LSB_FIRST = 5;
   localparam int CTL_MASTER = 4;
   localparam int CTL_CPOL = 3;
   localparam int CTL_CPHA = 2;
   localparam int CTL_RATE_HI = 1;
   localparam int CTL_RATE_LO = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;
   // Half-period of the generated clock in CPU cycles for rate codes 0..3
   // Fastest rate still spans the pin synchroniser delay before MISO is sampled
   localparam logic [6:0] HALF_DIV0 = 7'h06;
   localparam logic [6:0] HALF_DIV1 = 7'h08;
   localparam logic [6:0] HALF_DIV2 = 7'h20;
   localparam logic [6:0] HALF_DIV3 = 7'h40;
   localparam logic [6:0] DIV_ONE = 7'h01;
   localparam logic [6:0] DIV_ZERO = 7'h00;
   typedef enum logic [2:0] {
      SMS_IDLE = 3'b001,
      SMS_LEAD = 3'b010,
      SMS_TRAIL = 3'b100
   } sms_state_t;
endpackage

// ==== sms_sync3.sv ====
/*
 Three-stage input synchroniser with agreement filter.
 Assumes the input is asynchronous to clk; output changes when stages 2 and 3 agree.
*/
`timescale 1ns/1ps
module sms_sync3 (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reset_val,
   input wire logic d,
   output logic q
);
   logic s1_r, s2_r, s3_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         q <= 1'b0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            q <= s2_r;
         end
      end
   end
   logic unused_rv;
   assign unused_rv = reset_val;
endmodule

// ==== sms_shifter_chk.sv ====
/* Checker for sms_shifter: pin directions, done flag, interrupt and master framing.
   Assumes only the top-level ports and the sms_pkg field positions. */
`timescale 1ns/1ps
module sms_shifter_chk
   import sms_pkg::*;
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic POWER_GATE,
   input wire logic DATA_WR,
   input wire logic DIR_SEL,
   input wire logic SEL_IN,
   input wire logic MOSI_OE,
   input wire logic MISO_OE,
   input wire logic SCK_OUT,
   input wire logic SCK_OE,
   input wire logic SEL_OE,
   input wire logic [7:0] CONTROL,
   input wire logic TRANSFER_DONE_FLAG,
   input wire logic IRQ,
   input wire logic BUSY
);
   logic [4:0] tog_r;
   logic sck_r;
   wire logic [4:0] tog_nxt = DATA_WR ? 5'h00 : tog_r + {4'h0, SCK_OUT ^ sck_r};
   wire logic mst = CONTROL[CTL_ENABLE] && !POWER_GATE && CONTROL[CTL_MASTER];
   wire logic slv = CONTROL[CTL_ENABLE] && !POWER_GATE && !CONTROL[CTL_MASTER];
   wire logic sidle = !CONTROL[CTL_MASTER] && SEL_IN;
   // Generated clock edges since the last data write
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         tog_r <= 5'h00;
         sck_r <= 1'b0;
      end else begin
         tog_r <= tog_nxt;
         sck_r <= SCK_OUT;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   property p_irq; $rose(TRANSFER_DONE_FLAG) && CONTROL[CTL_IRQ_EN] |-> ##[0:1] IRQ; endproperty
   a_irq: assert property (p_irq) else $error("done flag gave no interrupt");
   property p_stop; $fell(BUSY) |-> ##[0:1] TRANSFER_DONE_FLAG; endproperty
   a_stop: assert property (p_stop) else $error("master stopped without done flag");
   property p_eight; $fell(BUSY) |=> tog_r == 5'h10; endproperty
   a_eight: assert property (p_eight) else $error("master byte not sixteen clock edges");
   property p_mdir; mst [*2] |-> !MISO_OE; endproperty
   a_mdir: assert property (p_mdir) else $error("master drives data input pin");
   property p_sdir; slv [*2] |-> !(MOSI_OE || SCK_OE || SEL_OE); endproperty
   a_sdir: assert property (p_sdir) else $error("slave drives an input pin");
   property p_nosel; (CONTROL[CTL_MASTER] && !DIR_SEL) [*2] |-> !SEL_OE; endproperty
   a_nosel: assert property (p_nosel) else $error("master drives select by itself");
   property p_idle; sidle [*6] |-> !MISO_OE; endproperty
   a_idle: assert property (p_idle) else $error("unselected slave drives data out");
   property p_hold; sidle [*6] |-> !$rose(TRANSFER_DONE_FLAG); endproperty
   a_hold: assert property (p_hold) else $error("unselected slave completed a byte");
   property p_fault; $fell(SEL_IN) && mst && !DIR_SEL |-> ##[1:8] (!CONTROL[CTL_MASTER] && TRANSFER_DONE_FLAG); endproperty
   a_fault: assert property (p_fault) else $error("select pulled low did not demote master");
endmodule
bind sms_shifter sms_shifter_chk sms_shifter_chk_inst (.CLK, .RSTN, .POWER_GATE, .DATA_WR, .DIR_SEL, .SEL_IN,
   .MOSI_OE, .MISO_OE, .SCK_OUT, .SCK_OE, .SEL_OE, .CONTROL, .TRANSFER_DONE_FLAG, .IRQ, .BUSY);

// ==== sms_peer.sv ====
/* Far-side peer: slave to our master (mode 0, msb first) and master to our slave.
   Assumes resolved pin levels on its inputs and a 6 ns link clock. */
`timescale 1ns/1ps
module sms_peer (
   input wire logic LCLK,
   input wire logic SCK,
   input wire logic SEL,
   input wire logic MOSI,
   input wire logic MISO,
   output logic PEER_SCK = 1'b0,
   output logic PEER_SEL = 1'b1,
   output logic PEER_MOSI = 1'b0,
   output logic PEER_MISO = 1'b0
);
   logic [7:0] reply = 8'h00;
   logic [7:0] got = 8'h00;
   logic [7:0] sh = 8'h00;
   always @(negedge SEL) begin
      sh = reply;
      PEER_MISO = reply[7];
   end
   always @(negedge SCK) if (!SEL && PEER_SEL) begin
      sh = {sh[6:0], 1'b0};
      PEER_MISO = sh[7];
   end
   // Released line shows the inverse of its last bit, never a held value
   always @(posedge SEL) PEER_MISO = ~PEER_MISO;
   always @(posedge SCK) got = {got[6:0], PEER_SEL ? MOSI : MISO};
   // Clock stands still between frames; half period stays above two CPU cycles
   task automatic send(input logic [7:0] b, input int n, input logic s);
      PEER_SEL = s;
      for (int i = 7; i > 7 - n; i--) begin
         PEER_MOSI = b[i];
         repeat (40) @(posedge LCLK);
         PEER_SCK = 1'b1;
         repeat (40) @(posedge LCLK);
         PEER_SCK = 1'b0;
      end
      repeat (40) @(posedge LCLK);
      PEER_SEL = 1'b1;
      PEER_MOSI = ~PEER_MOSI;
   endtask
endmodule

// ==== sms_shifter_test.sv ====
/* Testbench for sms_shifter: master bytes at all rates, gating, mode fault, slave bytes.
   Assumes sms_peer on the far side and the checker bound to the design. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
   $display("unexpected %s: expected %h seen %h", n, e, g); end end
module sms_shifter_test;
   import sms_pkg::*;
   logic CLK = 1'b0, LCLK = 1'b0, RSTN = 1'b0, POWER_GATE = 1'b0, CTL_WR = 1'b0, DATA_WR = 1'b0;
   logic DATA_RD = 1'b0, FLAG_CLR = 1'b0, DIR_MOSI = 1'b0, DIR_MISO = 1'b0, DIR_SCK = 1'b0, DIR_SEL = 1'b0;
   logic PORT_SEL_OUT = 1'b1;
   logic [7:0] CTL_WR_DATA = 8'h00, DATA_WR_DATA = 8'h00, CONTROL, RX_DATA, ctl, tx, rep;
   logic MOSI_OUT, MOSI_OE, MISO_OUT, MISO_OE, SCK_OUT, SCK_OE, SEL_OUT, SEL_OE;
   logic TRANSFER_DONE_FLAG, IRQ, BUSY, p_sck, p_sel, p_mosi, p_miso;
   wire logic MOSI_IN = MOSI_OE ? MOSI_OUT : p_mosi;
   wire logic MISO_IN = MISO_OE ? MISO_OUT : p_miso;
   wire logic SCK_IN = SCK_OE ? SCK_OUT : p_sck;
   wire logic SEL_IN = SEL_OE ? SEL_OUT : p_sel;
   int compares = 0, miscompares = 0;
   initial forever #10 CLK = ~CLK;
   initial begin
      #1.3;
      forever #3 LCLK = ~LCLK;
   end
   sms_shifter sms_shifter_inst (.CLK, .RSTN, .POWER_GATE, .CTL_WR_DATA, .CTL_WR, .DATA_WR_DATA, .DATA_WR,
      .DATA_RD, .FLAG_CLR, .DIR_MOSI, .DIR_MISO, .DIR_SCK, .DIR_SEL, .PORT_SEL_OUT, .MOSI_IN, .MISO_IN,
      .SCK_IN, .SEL_IN, .MOSI_OUT, .MOSI_OE, .MISO_OUT, .MISO_OE, .SCK_OUT, .SCK_OE, .SEL_OUT, .SEL_OE,
      .CONTROL, .RX_DATA, .TRANSFER_DONE_FLAG, .IRQ, .BUSY);
   sms_peer sms_peer_inst (.LCLK, .SCK(SCK_IN), .SEL(SEL_IN), .MOSI(MOSI_IN), .MISO(MISO_IN),
      .PEER_SCK(p_sck), .PEER_SEL(p_sel), .PEER_MOSI(p_mosi), .PEER_MISO(p_miso));
   function automatic logic [7:0] rev(input logic [7:0] b);
      return {<<{b}};
   endfunction
   task automatic end_of_test;
      if (miscompares == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // k: 0 control write, 1 data write, 2 data read, 3 flag clear
   task automatic strobe(input int k, input logic [7:0] d);
      @(negedge CLK);
      CTL_WR_DATA = d;
      DATA_WR_DATA = d;
      {CTL_WR, DATA_WR, DATA_RD, FLAG_CLR} = 4'h8 >> k;
      @(negedge CLK);
      {CTL_WR, DATA_WR, DATA_RD, FLAG_CLR} = 4'h0;
   endtask
   task automatic wait_flag;
      int n;
      n = 0;
      do begin
         @(negedge CLK);
         n++;
      end while (TRANSFER_DONE_FLAG !== 1'b1 && n < 4000);
      if (n == 4000) begin
         miscompares++;
         end_of_test;
      end
      @(negedge CLK);
   endtask
   initial begin
      repeat (5) @(negedge CLK);
      RSTN = 1'b1;
      repeat (5) @(negedge CLK);
      `CHK("control", 8'h00, CONTROL)
      {DIR_MOSI, DIR_SCK, DIR_SEL} = 3'h7;
      for (int r = 0; r < 4; r++) begin
         ctl = 8'hD0 | 8'(r) | (r[0] ? 8'h20 : 8'h00);
         tx = 8'hB1 + 8'(r);
         rep = 8'h4D - 8'(r);
         sms_peer_inst.reply = rep;
         strobe(0, ctl);
         `CHK("control", ctl, CONTROL)
         PORT_SEL_OUT = 1'b0;
         strobe(1, tx);
         wait_flag;
         `CHK("busy", 1'b0, BUSY)
         `CHK("irq", 1'b1, IRQ)
         `CHK("peer data", r[0] ? rev(tx) : tx, sms_peer_inst.got)
         `CHK("rx data", r[0] ? rev(rep) : rep, RX_DATA)
         PORT_SEL_OUT = 1'b1;
         strobe(3, 8'h00);
         `CHK("flag", 1'b0, TRANSFER_DONE_FLAG)
      end
      POWER_GATE = 1'b1;
      strobe(1, 8'h55);
      repeat (40) @(negedge CLK);
      `CHK("gated busy", 1'b0, BUSY)
      POWER_GATE = 1'b0;
      DIR_SEL = 1'b0;
      repeat (3) @(negedge CLK);
      sms_peer_inst.PEER_SEL = 1'b0;
      repeat (12) @(negedge CLK);
      `CHK("master bit", 1'b0, CONTROL[CTL_MASTER])
      `CHK("fault flag", 1'b1, TRANSFER_DONE_FLAG)
      sms_peer_inst.PEER_SEL = 1'b1;
      {DIR_MOSI, DIR_SCK, DIR_MISO} = 3'h1;
      strobe(0, 8'h40);
      strobe(3, 8'h00);
      strobe(1, 8'h3C);
      sms_peer_inst.send(8'hF0, 8, 1'b1);
      repeat (8) @(negedge CLK);
      `CHK("idle flag", 1'b0, TRANSFER_DONE_FLAG)
      `CHK("idle drive", 1'b0, MISO_OE)
      sms_peer_inst.send(8'h96, 8, 1'b0);
      wait_flag;
      `CHK("peer data", 8'h3C, sms_peer_inst.got)
      `CHK("rx data", 8'h96, RX_DATA)
      strobe(1, 8'hC3);
      strobe(2, 8'h00);
      sms_peer_inst.send(8'h5A, 8, 1'b0);
      wait_flag;
      `CHK("peer data", 8'hC3, sms_peer_inst.got)
      `CHK("rx data", 8'h5A, RX_DATA)
      strobe(2, 8'h00);
      sms_peer_inst.send(8'hE7, 3, 1'b0);
      repeat (8) @(negedge CLK);
      `CHK("partial flag", 1'b0, TRANSFER_DONE_FLAG)
      sms_peer_inst.send(8'h69, 8, 1'b0);
      wait_flag;
      `CHK("rx data", 8'h69, RX_DATA)
      end_of_test;
   end
endmodule
